/* File: rtl/flash_cmd_front.sv */
// Serial flash command front end: identification reads, secure area, write latch, soft reset
//
// Operation
// - Ident opcode returns maker plus two-byte device code
// - Ident bytes on falling edges, repeat while selected
// - Ident opcode not decoded while program/erase busy
// - Signature opcode, three dummies, one signature byte
// - Signature repeats; host reads one whole first
// - Address zero maker first, one device first
// - Pair bytes out on falling edges, MSB first
// - Pair bytes alternate until chip select rises
// - Enter/leave opcodes switch secure area access
// - Idle, arm, execute; execute only right after arm
// - Framed latch-set opcode sets write latch
// - Framed latch-clear opcode clears write latch
// - Latch clears on reset, suspend, completions
// - Lock write sets permanent lock, clears latch
// - Upper I/O lines ignored by these commands
// - Chip select high returns to standby
// - Writes ignored unless write latch set
`timescale 1ns/1ps
module flash_cmd_front (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sclk_link_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic reset_pin_n_i,
  input wire logic pe_busy_i,
  input wire logic pe_done_i,
  input wire logic pe_suspend_i,
  output logic so_o,
  output logic so_oe_o,
  output logic write_enable_latch_o,
  output logic secure_area_o,
  output logic lock_down_o,
  output logic soft_reset_o,
  output logic pe_request_o,
  output logic [7:0] pe_opcode_o
);

  // ****************************************************************
  // Link domain: frame counting and opcode capture
  // ****************************************************************
  logic started_ff;
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [2:0] bitpos_ff;
  logic [7:0] shift_ff;
  logic [7:0] nxt_byte;
  logic [7:0] opcode_ff;
  logic frame_tog_ff;
  logic busy_l1_ff;
  logic busy_l2_ff;
  logic busy_ff;
  logic seen_tog_ff;

  // Only the single data line is sampled; upper I/O lines have no path in
  assign nxt_byte = {shift_ff[6:0], si_i};

  always_comb begin
    if (!started_ff) begin
      nxt_cnt = flash_cmd_pkg::COUNT_FIRST;
    end else if (cnt_ff == flash_cmd_pkg::COUNT_MAX) begin
      nxt_cnt = cnt_ff;
    end else begin
      nxt_cnt = cnt_ff + 6'h01;
    end
  end

  // Chip select high clears the frame state; no clock edge is needed
  always_ff @(posedge sclk_link_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      started_ff <= 1'b0;
    end else begin
      started_ff <= 1'b1;
    end
  end

  // Held across deselect so the system side reads a stable result
  always_ff @(posedge sclk_link_i) begin
    cnt_ff <= nxt_cnt;
    shift_ff <= nxt_byte;
    bitpos_ff <= started_ff ? bitpos_ff + 3'h1 : 3'h1;
    // Marks a new frame against the system side's last seen value, so no reset is needed
    if (!started_ff) begin
      frame_tog_ff <= ~seen_tog_ff;
    end
    if (nxt_cnt == flash_cmd_pkg::OPCODE_BITS) begin
      opcode_ff <= nxt_byte;
    end
  end

  // Busy flag brought into the link domain
  always_ff @(posedge sclk_link_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      busy_l1_ff <= 1'b0;
      busy_l2_ff <= 1'b0;
    end else begin
      busy_l1_ff <= busy_ff;
      busy_l2_ff <= busy_l1_ff;
    end
  end

  // ****************************************************************
  // Link domain: output pattern sequencing
  // ****************************************************************
  flash_cmd_pkg::out_mode_t mode_ff;
  flash_cmd_pkg::out_mode_t nxt_mode;
  logic [4:0] ptr_ff;
  logic [4:0] nxt_ptr;
  logic swap_ff;
  logic nxt_swap;
  logic [2:0] rom_sel;
  logic [7:0] rom_data;
  logic so_ff;
  logic so_oe_ff;

  function automatic logic [4:0] ptr_step(input logic [4:0] ptr, input logic [4:0] last);
    ptr_step = (ptr == last) ? 5'h00 : ptr + 5'h01;
  endfunction

  function automatic logic [2:0] byte_select(input flash_cmd_pkg::out_mode_t mode,
                                             input logic [4:0] ptr, input logic swap);
    logic [2:0] sel;
    sel = flash_cmd_pkg::SEL_MAKER;
    unique case (mode)
      flash_cmd_pkg::MODE_IDENT: begin
        if (ptr[4:3] == 2'h0) begin
          sel = flash_cmd_pkg::SEL_MAKER;
        end else if (ptr[4:3] == 2'h1) begin
          sel = flash_cmd_pkg::SEL_TYPE;
        end else begin
          sel = flash_cmd_pkg::SEL_DENSITY;
        end
      end
      flash_cmd_pkg::MODE_SIG: sel = flash_cmd_pkg::SEL_SIGNATURE;
      flash_cmd_pkg::MODE_PAIR: begin
        sel = (ptr[3] ^ swap) ? flash_cmd_pkg::SEL_PAIR_DEVICE : flash_cmd_pkg::SEL_MAKER;
      end
      flash_cmd_pkg::MODE_NONE: sel = flash_cmd_pkg::SEL_MAKER;
      default: sel = flash_cmd_pkg::SEL_MAKER;
    endcase
    byte_select = sel;
  endfunction

  always_comb begin
    nxt_mode = mode_ff;
    nxt_ptr = ptr_ff;
    nxt_swap = swap_ff;
    if (!started_ff) begin
      nxt_mode = flash_cmd_pkg::MODE_NONE;
      nxt_ptr = 5'h00;
      nxt_swap = 1'b0;
    end else if ((nxt_cnt == flash_cmd_pkg::OPCODE_BITS)
                 && (nxt_byte == flash_cmd_pkg::OP_STANDARD_IDENT_READ)) begin
      nxt_mode = busy_l2_ff ? flash_cmd_pkg::MODE_NONE : flash_cmd_pkg::MODE_IDENT;
      nxt_ptr = 5'h00;
    end else if ((nxt_cnt == flash_cmd_pkg::HEADER_BITS)
                 && (opcode_ff == flash_cmd_pkg::OP_LEGACY_SIGNATURE_READ)) begin
      nxt_mode = flash_cmd_pkg::MODE_SIG;
      nxt_ptr = 5'h00;
    end else if ((nxt_cnt == flash_cmd_pkg::HEADER_BITS)
                 && (opcode_ff == flash_cmd_pkg::OP_MAKER_DEVICE_PAIR_READ)) begin
      nxt_mode = flash_cmd_pkg::MODE_PAIR;
      nxt_ptr = 5'h00;
      nxt_swap = (nxt_byte == flash_cmd_pkg::PAIR_ADDR_DEVICE_FIRST);
    end else begin
      unique case (mode_ff)
        flash_cmd_pkg::MODE_IDENT: nxt_ptr = ptr_step(ptr_ff, flash_cmd_pkg::IDENT_LAST);
        flash_cmd_pkg::MODE_SIG: nxt_ptr = ptr_step(ptr_ff, flash_cmd_pkg::SIG_LAST);
        flash_cmd_pkg::MODE_PAIR: nxt_ptr = ptr_step(ptr_ff, flash_cmd_pkg::PAIR_LAST);
        flash_cmd_pkg::MODE_NONE: nxt_ptr = ptr_ff;
        default: nxt_ptr = ptr_ff;
      endcase
    end
    rom_sel = byte_select(nxt_mode, nxt_ptr, nxt_swap);
  end

  // Deselect ends any read at once and drops back to standby
  always_ff @(posedge sclk_link_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      mode_ff <= flash_cmd_pkg::MODE_NONE;
      ptr_ff <= 5'h00;
      swap_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      ptr_ff <= nxt_ptr;
      swap_ff <= nxt_swap;
    end
  end

  ident_rom u_ident_rom (
    .clk_link_i(sclk_link_i),
    .sel_i(rom_sel),
    .data_o(rom_data)
  );

  // Data changes on the falling edge, most significant bit first
  always_ff @(negedge sclk_link_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else begin
      so_oe_ff <= (mode_ff != flash_cmd_pkg::MODE_NONE);
      so_ff <= rom_data[~ptr_ff[2:0]];
    end
  end

  assign so_o = so_ff;
  assign so_oe_o = so_oe_ff;

  // ****************************************************************
  // System domain: synchronisers and frame end detection
  // ****************************************************************
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_prev_ff;
  logic rp_s1_ff;
  logic rp_s2_ff;
  logic frame_end;
  logic frame_new;
  logic whole_cmd;
  logic one_byte;
  logic long_cmd;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      rp_s1_ff <= 1'b1;
      rp_s2_ff <= 1'b1;
      busy_ff <= 1'b0;
      seen_tog_ff <= 1'b0;
    end else begin
      cs_s1_ff <= cs_n_i;
      cs_s2_ff <= cs_s1_ff;
      cs_prev_ff <= cs_s2_ff;
      rp_s1_ff <= reset_pin_n_i;
      rp_s2_ff <= rp_s1_ff;
      busy_ff <= pe_busy_i;
      if (frame_end) begin
        seen_tog_ff <= frame_tog_ff;
      end
    end
  end

  // Link words are quiet while chip select is high, so they are read here directly
  assign frame_end = cs_s2_ff & ~cs_prev_ff;
  assign frame_new = frame_end & (frame_tog_ff != seen_tog_ff);
  assign whole_cmd = frame_new & (cnt_ff >= flash_cmd_pkg::OPCODE_BITS)
                     & (bitpos_ff == 3'h0);
  assign one_byte = frame_new & (cnt_ff == flash_cmd_pkg::OPCODE_BITS);
  assign long_cmd = whole_cmd;

  function automatic logic is_write_op(input logic [7:0] op);
    is_write_op = (op == flash_cmd_pkg::OP_PAGE_WRITE) || (op == flash_cmd_pkg::OP_QUAD_PAGE_WRITE)
                  || (op == flash_cmd_pkg::OP_SECTOR_WIPE) || (op == flash_cmd_pkg::OP_HALF_BLOCK_WIPE)
                  || (op == flash_cmd_pkg::OP_FULL_BLOCK_WIPE) || (op == flash_cmd_pkg::OP_CHIP_WIPE_A)
                  || (op == flash_cmd_pkg::OP_CHIP_WIPE_B)
                  || (op == flash_cmd_pkg::OP_STATUS_WRITE_CMD);
  endfunction

  // ****************************************************************
  // System domain: command effects
  // ****************************************************************
  logic wel_ff;
  logic secure_ff;
  logic lock_ff;
  logic arm_ff;
  logic soft_rst_ff;
  logic pe_req_ff;
  logic [7:0] pe_op_ff;
  logic latch_set;
  logic latch_clear;
  logic lock_go;
  logic reset_go;
  logic write_go;

  assign latch_set = one_byte && (opcode_ff == flash_cmd_pkg::OP_WRITE_LATCH_SET_CMD);
  assign lock_go = one_byte && (opcode_ff == flash_cmd_pkg::OP_SECURITY_REG_LOCK_WRITE);
  assign reset_go = one_byte && arm_ff && (opcode_ff == flash_cmd_pkg::OP_SOFT_RESET_GO);
  assign write_go = long_cmd && is_write_op(opcode_ff) && wel_ff && !busy_ff;
  assign latch_clear = !rp_s2_ff || pe_done_i || pe_suspend_i || lock_go || reset_go
                       || (one_byte && (opcode_ff == flash_cmd_pkg::OP_WRITE_LATCH_CLEAR_CMD));

  // A set arriving with a clear wins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wel_ff <= 1'b0;
    end else if (latch_set) begin
      wel_ff <= 1'b1;
    end else if (latch_clear) begin
      wel_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      secure_ff <= 1'b0;
    end else if (one_byte && (opcode_ff == flash_cmd_pkg::OP_SECURE_AREA_ENTER)) begin
      secure_ff <= 1'b1;
    end else if (reset_go
                 || (one_byte && (opcode_ff == flash_cmd_pkg::OP_SECURE_AREA_LEAVE))) begin
      secure_ff <= 1'b0;
    end
  end

  // Once set, nothing but a power-on reset brings it back
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lock_ff <= 1'b0;
    end else if (lock_go) begin
      lock_ff <= 1'b1;
    end
  end

  // Any complete command other than the arm opcode disarms the reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      arm_ff <= 1'b0;
    end else if (whole_cmd) begin
      arm_ff <= one_byte && (opcode_ff == flash_cmd_pkg::OP_SOFT_RESET_ARM);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      soft_rst_ff <= 1'b0;
      pe_req_ff <= 1'b0;
      pe_op_ff <= 8'h00;
    end else begin
      soft_rst_ff <= reset_go;
      pe_req_ff <= write_go;
      if (write_go) begin
        pe_op_ff <= opcode_ff;
      end
    end
  end

  assign write_enable_latch_o = wel_ff;
  assign secure_area_o = secure_ff;
  assign lock_down_o = lock_ff;
  assign soft_reset_o = soft_rst_ff;
  assign pe_request_o = pe_req_ff;
  assign pe_opcode_o = pe_op_ff;

endmodule // flash_cmd_front

/* File: pkg/flash_cmd_pkg.sv */
// Opcodes, frame counts, pattern lengths and state types of the flash command front end
package flash_cmd_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_STANDARD_IDENT_READ = 8'h9F;
  localparam logic [7:0] OP_LEGACY_SIGNATURE_READ = 8'hAB;
  localparam logic [7:0] OP_MAKER_DEVICE_PAIR_READ = 8'h90;
  localparam logic [7:0] OP_SECURE_AREA_ENTER = 8'hB1;
  localparam logic [7:0] OP_SECURE_AREA_LEAVE = 8'hC1;
  localparam logic [7:0] OP_SECURITY_REG_READ = 8'h2B;
  localparam logic [7:0] OP_SECURITY_REG_LOCK_WRITE = 8'h2F;
  localparam logic [7:0] OP_IDLE_OPCODE = 8'h00;
  localparam logic [7:0] OP_SOFT_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_SOFT_RESET_GO = 8'h99;
  localparam logic [7:0] OP_WRITE_LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR_CMD = 8'h04;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h38;
  localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] OP_FULL_BLOCK_WIPE = 8'hD8;
  localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B = 8'hC7;
  localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;

  // ****************************************************************
  // Frame bit counts and pair address value
  // ****************************************************************
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] HEADER_BITS = 6'h20;
  localparam logic [5:0] COUNT_MAX = 6'h3F;
  localparam logic [5:0] COUNT_FIRST = 6'h01;
  localparam logic [7:0] PAIR_ADDR_DEVICE_FIRST = 8'h01;

  // ****************************************************************
  // Output pattern lengths in bits, minus one
  // ****************************************************************
  localparam logic [4:0] IDENT_LAST = 5'h17;
  localparam logic [4:0] SIG_LAST = 5'h07;
  localparam logic [4:0] PAIR_LAST = 5'h0F;

  // ****************************************************************
  // Identification byte selectors
  // ****************************************************************
  localparam logic [2:0] SEL_MAKER = 3'h0;
  localparam logic [2:0] SEL_TYPE = 3'h1;
  localparam logic [2:0] SEL_DENSITY = 3'h2;
  localparam logic [2:0] SEL_SIGNATURE = 3'h3;
  localparam logic [2:0] SEL_PAIR_DEVICE = 3'h4;

  typedef enum logic [3:0] {
    MODE_NONE = 4'b0001,
    MODE_IDENT = 4'b0010,
    MODE_SIG = 4'b0100,
    MODE_PAIR = 4'b1000
  } out_mode_t;

endpackage

/* File: rtl/ident_rom.sv */
// Identification byte table with registered read data on the link clock
`timescale 1ns/1ps
module ident_rom #(
  // All codes below are arbitrary neutral values
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] TYPE_CODE = 8'h3C,
  parameter logic [7:0] DENSITY_CODE = 8'h4B,
  parameter logic [7:0] SIGNATURE_CODE = 8'h4B,
  parameter logic [7:0] PAIR_DEVICE_CODE = 8'h4B
) (
  input wire logic clk_link_i,
  input wire logic [2:0] sel_i,
  output logic [7:0] data_o
);

  logic [7:0] data_ff;

  always_ff @(posedge clk_link_i) begin
    unique case (sel_i)
      flash_cmd_pkg::SEL_MAKER: data_ff <= MAKER_CODE;
      flash_cmd_pkg::SEL_TYPE: data_ff <= TYPE_CODE;
      flash_cmd_pkg::SEL_DENSITY: data_ff <= DENSITY_CODE;
      flash_cmd_pkg::SEL_SIGNATURE: data_ff <= SIGNATURE_CODE;
      flash_cmd_pkg::SEL_PAIR_DEVICE: data_ff <= PAIR_DEVICE_CODE;
      default: data_ff <= MAKER_CODE;
    endcase
  end

  assign data_o = data_ff;

endmodule // ident_rom

/* File: verification/flash_cmd_front_assertions.sv */
// Concurrent checks on the ports of the flash command front end
`timescale 1ns/1ps
module flash_cmd_front_assertions (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sclk_link_i,
  input wire logic cs_n_i,
  input wire logic reset_pin_n_i,
  input wire logic pe_done_i,
  input wire logic pe_suspend_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic write_enable_latch_o,
  input wire logic secure_area_o,
  input wire logic lock_down_o,
  input wire logic soft_reset_o,
  input wire logic pe_request_o
);
  logic cs_q_ff;
  logic [3:0] since_rise_ff;
  logic [5:0] bits_ff;
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    cs_q_ff <= cs_n_i;
    if (!rst_n_i) begin
      since_rise_ff <= 4'hF;
    end else if (cs_n_i && !cs_q_ff) begin
      since_rise_ff <= 4'h0;
    end else if (since_rise_ff != 4'hF) begin
      since_rise_ff <= since_rise_ff + 4'h1;
    end
  end
  always_ff @(posedge sclk_link_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bits_ff <= 6'h00;
    end else if (bits_ff != 6'h3F) begin
      bits_ff <= bits_ff + 6'h01;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_SO_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cs_n_i |-> !so_oe_o && !so_o) else $error("serial output active while deselected");
  AST_OE_START: assert property (@(posedge sclk_link_i) disable iff (cs_n_i || !rst_n_i)
    $rose(so_oe_o) |-> (bits_ff == 6'h08 || bits_ff == 6'h20))
    else $error("output enable rose at a wrong bit count");
  AST_WEL_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(write_enable_latch_o) |-> since_rise_ff <= 4'h7)
    else $error("write latch set without a frame end");
  AST_PIN_CLR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !reset_pin_n_i [*5] |-> !write_enable_latch_o || $rose(write_enable_latch_o))
    else $error("write latch held while reset pin low");
  AST_DONE_CLR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (pe_done_i || pe_suspend_i) |=> ##[0:2] !write_enable_latch_o)
    else $error("write latch not cleared by completion or suspend");
  AST_REQ_WEL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    pe_request_o |-> $past(write_enable_latch_o)) else $error("write accepted without latch");
  AST_REQ_PULSE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    pe_request_o |=> !pe_request_o) else $error("write request longer than one cycle");
  AST_SRST_CLR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    soft_reset_o |=> !soft_reset_o && !write_enable_latch_o && !secure_area_o)
    else $error("soft reset did not clear state");
  AST_LOCK_STICKY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !$fell(lock_down_o)) else $error("lock bit cleared");
endmodule // flash_cmd_front_assertions
bind flash_cmd_front flash_cmd_front_assertions flash_cmd_front_assertions_i (.*);

/* File: verification/flash_host_model.sv */
// Host serial controller model: mode 0 frames, clock only inside frames
`timescale 1ns/1ps
module flash_host_model (
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    cs_n_o = 1'b0;
    sclk_o = 1'b0;
    si_o = 1'b1;
    // A clean deselect edge clears the device's link state at start-up
    #1 cs_n_o = 1'b1;
  end
  // Send ntx bits MSB first, then clock nrx bits in at rising edges
  task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx,
                      output logic [31:0] rx);
    rx = '0;
    #11 cs_n_o = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      si_o = (i < ntx) ? tx[ntx - 1 - i] : ~si_o;
      #24 sclk_o = 1'b1;
      if (i >= ntx) rx = {rx[30:0], so_i};
      #24 sclk_o = 1'b0;
    end
    #24 cs_n_o = 1'b1;
    si_o = ~si_o;
    #60;
  endtask
endmodule // flash_host_model

/* File: verification/flash_cmd_front_tb.sv */
// Self-checking bench for the flash command front end
`timescale 1ns/1ps
module flash_cmd_front_tb;
  // Identification codes: arbitrary neutral values matching the table
  localparam logic [7:0] MAKER = 8'h5A;
  localparam logic [7:0] MTYPE = 8'h3C;
  localparam logic [7:0] DENS = 8'h4B;
  localparam logic [7:0] SIG = 8'h4B;
  localparam logic [7:0] DEV = 8'h4B;
  logic clk_sys_i, rst_n_i, cs_n, sclk, si, pin_n, busy, done, susp;
  logic so, so_oe, write_enable_latch, sec, lock, srst, req;
  logic [7:0] pe_op;
  logic [7:0] wops [8] = '{8'h02, 8'h38, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h01};
  logic [31:0] rx;
  int failures, num_checks, n_srst, n_req, n_oe;
  flash_cmd_front flash_cmd_front_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .sclk_link_i(sclk), .cs_n_i(cs_n), .si_i(si), .reset_pin_n_i(pin_n),
    .pe_busy_i(busy), .pe_done_i(done), .pe_suspend_i(susp), .so_o(so), .so_oe_o(so_oe),
    .write_enable_latch_o(write_enable_latch), .secure_area_o(sec), .lock_down_o(lock),
    .soft_reset_o(srst), .pe_request_o(req), .pe_opcode_o(pe_op));
  flash_host_model flash_host_model_i (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so));
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (srst === 1'b1) n_srst++;
    if (req === 1'b1) n_req++;
  end
  always @(posedge sclk) if (so_oe === 1'b1) n_oe++;
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input int n = 8);
    flash_host_model_i.xfer({24'h0, op} << (n - 8), n, 0, rx);
    repeat (10) @(posedge clk_sys_i);
  endtask
  task automatic pulse_done();
    done <= 1'b1;
    @(posedge clk_sys_i);
    done <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_ident();
    flash_host_model_i.xfer(32'h9F, 8, 32, rx);
    check(rx, {MAKER, MTYPE, DENS, MAKER}, "ident read");
    flash_host_model_i.xfer(32'h9F, 8, 5, rx);
    check(rx, {27'h0, MAKER[7:3]}, "ident cut short");
    check(so_oe, 1'b0, "standby after ident");
    flash_host_model_i.xfer(32'hAB000000, 32, 16, rx);
    check(rx, {16'h0, SIG, SIG}, "signature");
    for (int a = 0; a < 2; a++) begin
      flash_host_model_i.xfer({8'h90, 16'h0, 8'(a)}, 32, 32, rx);
      check(rx, a ? {DEV, MAKER, DEV, MAKER} : {MAKER, DEV, MAKER, DEV}, "pair");
    end
    $display("test ident done");
  endtask
  task automatic t_latch();
    cmd(8'h06);
    check(write_enable_latch, 1'b1, "latch set");
    cmd(8'h04);
    check(write_enable_latch, 1'b0, "latch clear");
    cmd(8'h06, 9);
    cmd(8'h00, 4);
    check(write_enable_latch, 1'b0, "partial or long frame");
    for (int k = 0; k < 3; k++) begin
      cmd(8'h06);
      done <= (k == 0);
      susp <= (k == 1);
      pin_n <= (k != 2);
      repeat (k == 2 ? 6 : 1) @(posedge clk_sys_i);
      done <= 1'b0;
      susp <= 1'b0;
      pin_n <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      check(write_enable_latch, 1'b0, "latch clear event");
    end
    $display("test latch done");
  endtask
  task automatic t_write();
    flash_host_model_i.xfer(32'h02000000, 32, 0, rx);
    repeat (10) @(posedge clk_sys_i);
    check(32'(n_req), 32'd0, "write without latch");
    for (int k = 0; k < 8; k++) begin
      cmd(8'h06);
      flash_host_model_i.xfer({wops[k], 24'h0}, 32, 0, rx);
      repeat (10) @(posedge clk_sys_i);
      check(32'(n_req), 32'(k + 1), "write request");
      check(pe_op, wops[k], "write opcode");
      pulse_done();
    end
    busy <= 1'b1;
    cmd(8'h06);
    n_oe = 0;
    flash_host_model_i.xfer(32'h9F, 8, 16, rx);
    flash_host_model_i.xfer(32'h02000000, 32, 0, rx);
    repeat (10) @(posedge clk_sys_i);
    check(32'(n_oe), 32'd0, "ident while busy");
    check(32'(n_req), 32'd8, "write while busy");
    busy <= 1'b0;
    cmd(8'h04);
    $display("test write done");
  endtask
  task automatic t_misc();
    cmd(8'hB1);
    check(sec, 1'b1, "secure enter");
    cmd(8'hC1);
    check(sec, 1'b0, "secure leave");
    cmd(8'h06);
    cmd(8'hB1);
    cmd(8'h66);
    cmd(8'h00);
    cmd(8'h99);
    check(32'(n_srst), 32'd0, "reset not armed");
    cmd(8'h66);
    cmd(8'h99);
    check(32'(n_srst), 32'd1, "soft reset");
    check({write_enable_latch, sec}, 2'b00, "soft reset clears");
    cmd(8'h06);
    cmd(8'h2F);
    check({lock, write_enable_latch}, 2'b10, "lock write");
    $display("test misc done");
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    stop_test();
  end
  initial begin
    rst_n_i = 1'b0;
    pin_n = 1'b1;
    busy = 1'b0;
    done = 1'b0;
    susp = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_ident();
    t_latch();
    t_write();
    t_misc();
    stop_test();
  end
endmodule // flash_cmd_front_tb
